/* bench/lsb_ctrl_monitor.sv */
// assertion checker watching the led sink controller ports
`timescale 1ns/1ps
module lsb_ctrl_monitor #(
	parameter MS_TICK_CYC = 125000
) (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [15:0] i_reg_addr,
	input wire [15:0] i_reg_wdata,
	input wire [15:0] o_reg_rdata,
	input wire [2:0] i_channel_on_bit,
	input wire [2:0] o_sink_on,
	input wire [8:0] o_coarse_current_step
);
reg [15:0] dm0;
reg [15:0] cs0;
reg [10:0] n_on;
wire [2:0] st0 = o_coarse_current_step[2:0];
wire [2:0] en = i_channel_on_bit;
// shadow channel 0 duty-mode and current-softstart registers, count cycles since its enable rose
always @(posedge i_sys_clk or posedge i_rst) begin
	if (i_rst) begin
		dm0 <= 16'h0000;
		cs0 <= 16'h0000;
		n_on <= 11'h000;
	end else begin
		if (i_reg_wr && i_reg_addr == 16'h0330)
			dm0 <= i_reg_wdata;
		if (i_reg_wr && i_reg_addr == 16'h0334)
			cs0 <= i_reg_wdata;
		if (!en[0])
			n_on <= 11'h000;
		else if (n_on != 11'h7ff)
			n_on <= n_on + 11'h001;
	end
end
default clocking @(posedge i_sys_clk); endclocking
default disable iff (i_rst);
property p_rd_bad;
	i_reg_rd && (i_reg_addr == 16'h0346 || i_reg_addr[0]) |=> o_reg_rdata == 16'h0000;
endproperty
a_rd_bad: assert property (p_rd_bad) else $error("refused read not zero");
property p_rd_hold;
	!i_reg_rd |=> $stable(o_reg_rdata);
endproperty
a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
property p_rd_back;
	i_reg_wr && !i_reg_rd && i_reg_addr == 16'h0332 ##1 i_reg_rd && !i_reg_wr
		&& i_reg_addr == 16'h0332 |=> o_reg_rdata == $past(i_reg_wdata, 2);
endproperty
a_rd_back: assert property (p_rd_back) else $error("freq code lost");
property p_off;
	(o_sink_on & ~(en | $past(en) | $past(en, 2) | $past(en, 3) | $past(en, 4))) == 3'h0;
endproperty
a_off: assert property (p_off) else $error("disabled sink on");
property p_steady;
	(en[0] && dm0[3])[*6] |-> o_sink_on[0];
endproperty
a_steady: assert property (p_steady) else $error("steady mode off");
property p_full;
	(en[0] && dm0[3:2] == 2'h0 && dm0[12:8] == 5'h1f)[*6] |-> o_sink_on[0];
endproperty
a_full: assert property (p_full) else $error("full duty gap");
property p_step;
	(!cs0[0] && $stable(cs0))[*4] |-> st0 == ((cs0[14:12] > 3'h5) ? 3'h5 : cs0[14:12]);
endproperty
a_step: assert property (p_step) else $error("step differs");
property p_ss_slow;
	n_on == 11'h0f0 && cs0[0] && cs0[2:1] == 2'h3 |-> st0 == 3'h0;
endproperty
a_ss_slow: assert property (p_ss_slow) else $error("soft start fast");
property p_ss_reach;
	n_on == 11'h578 && cs0[0] && cs0[14:12] <= 3'h5 |-> st0 == cs0[14:12];
endproperty
a_ss_reach: assert property (p_ss_reach) else $error("soft start stuck");
c_back: cover property (p_rd_back);
c_full: cover property (en[0] && dm0[12:8] == 5'h1f && o_sink_on[0]);
c_ss: cover property (n_on == 11'h578 && cs0[0]);
endmodule
bind lsb_ctrl lsb_ctrl_monitor #(.MS_TICK_CYC(MS_TICK_CYC)) i_mon (.i_sys_clk, .i_rst,
	.i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_channel_on_bit,
	.o_sink_on, .o_coarse_current_step);

/* bench/lsb_sink_model.sv */
// behavioural current sink stage that totals the cycles a chosen sink draws current
`timescale 1ns/1ps
module lsb_sink_model (
	input wire i_sys_clk,
	input wire i_clr,
	input wire [1:0] i_sel,
	input wire [2:0] i_sink_on,
	output reg [31:0] o_on_cycles
);
// accumulate on time of the selected sink, cleared on request
always @(posedge i_sys_clk) begin
	if (i_clr) begin
		o_on_cycles <= 32'h0000_0000;
	end else begin
		o_on_cycles <= o_on_cycles + {31'h0000_0000, i_sink_on[i_sel]};
	end
end
endmodule

/* bench/testbench.sv */
// self-checking bench for the led sink controller
`timescale 1ns/1ps
module testbench;
reg i_sys_clk;
reg i_rst;
reg i_reg_wr;
reg i_reg_rd;
reg [15:0] i_reg_addr;
reg [15:0] i_reg_wdata;
reg [2:0] i_channel_on_bit;
reg [2:0] i_indicator_sel;
wire [15:0] o_reg_rdata;
wire [2:0] o_sink_on;
wire [8:0] o_coarse_current_step;
wire [31:0] on_cyc;
reg [1:0] sel;
reg clr;
reg pend;
reg [4:0] du;
reg [15:0] d;
logic [15:0] exp_q[$];
logic [15:0] msk[4] = '{16'h1f0c, 16'hffff, 16'h7007, 16'hff0f};
int n_errors = 0;
int samples_checked = 0;
lsb_ctrl #(.MS_TICK_CYC(10)) i_dut (.i_sys_clk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
	.i_reg_wdata, .o_reg_rdata, .i_channel_on_bit, .i_indicator_sel, .o_sink_on,
	.o_coarse_current_step);
lsb_sink_model i_sink (.i_sys_clk, .i_clr(clr), .i_sel(sel), .i_sink_on(o_sink_on),
	.o_on_cycles(on_cyc));
// free running 125 MHz clock
initial begin
	i_sys_clk = 1'b0;
	forever #4 i_sys_clk = ~i_sys_clk;
end
task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [15:0] v);
	i_reg_wr = w;
	i_reg_rd = r;
	i_reg_addr = a;
	i_reg_wdata = v;
	@(negedge i_sys_clk);
endtask
task automatic rd(input logic [15:0] a, input logic [15:0] e);
	exp_q.push_back(e);
	bus(1'b0, 1'b1, a, 16'h0000);
endtask
task automatic cmp(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
	samples_checked++;
	if ((got >= lo && got <= hi) !== 1'b1) begin
		n_errors++;
		$display("[ERR] %0t got %h expected %h..%h", $time, got, lo, hi);
	end
endtask
task automatic cmp_rd(input logic [15:0] got, input logic [15:0] e);
	cmp({16'h0000, got}, {16'h0000, e}, {16'h0000, e});
endtask
// settle, then count sink on cycles through the sink model
task automatic meas(input logic [1:0] c, input int s, input int n, input int lo, input int hi);
	sel = c;
	clr = 1'b1;
	bus(1'b0, 1'b0, 16'h0000, 16'h0000);
	repeat (s) @(negedge i_sys_clk);
	clr = 1'b0;
	repeat (n) @(negedge i_sys_clk);
	cmp(on_cyc, 32'(lo), 32'(hi));
endtask
task automatic results();
	if (exp_q.size() != 0)
		n_errors++;
	$display("checked %0d mismatches %0d", samples_checked, n_errors);
	if (n_errors == 0 && samples_checked > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask
// compare each read result with the oldest noted value
always @(posedge i_sys_clk) begin
	if (pend)
		cmp_rd(o_reg_rdata, exp_q.pop_front());
	pend <= i_reg_rd;
end
// cut a hung run short
initial begin
	#400_000;
	n_errors++;
	results();
end
initial begin
	d = 16'($urandom(34033));
	i_rst = 1'b1;
	i_channel_on_bit = 3'b000;
	i_indicator_sel = 3'b001;
	sel = 2'b00;
	clr = 1'b1;
	pend = 1'b0;
	bus(1'b0, 1'b0, 16'h0000, 16'h0000);
	repeat (3) @(negedge i_sys_clk);
	i_rst = 1'b0;
	// reset values, then random write and immediate read back
	for (int i = 0; i < 11; i++)
		rd(16'(16'h0330 + 2 * i), 16'h0000);
	for (int i = 0; i < 11; i++) begin
		d = 16'($urandom);
		bus(1'b1, 1'b0, 16'(16'h0330 + 2 * i), d);
		rd(16'(16'h0330 + 2 * i), d & msk[i % 4]);
	end
	bus(1'b1, 1'b0, 16'h0346, 16'hffff);
	rd(16'h0346, 16'h0000);
	rd(16'h0331, 16'h0000);
	// steady modes 10 and 11 hold the sink on, enable low forces it off
	i_channel_on_bit = 3'b001;
	for (int m = 2; m < 4; m++) begin
		bus(1'b1, 1'b0, 16'h0330, 16'(m * 4));
		meas(2'b00, 8, 100, 100, 100);
	end
	i_channel_on_bit = 3'b000;
	meas(2'b00, 8, 100, 0, 0);
	// pwm at 32 ms period on the shortened tick, two periods counted
	i_channel_on_bit = 3'b001;
	bus(1'b1, 1'b0, 16'h0332, 16'h001f);
	for (int k = 0; k < 4; k++) begin
		du = (k == 3) ? 5'h1f : 5'($urandom);
		bus(1'b1, 1'b0, 16'h0330, {3'b000, du, 8'h00});
		meas(2'b00, 400, 640, 20 * (du + 1), 20 * (du + 1));
	end
	// backlight base on channel 1, two 16 us ticks a period at half duty
	i_channel_on_bit = 3'b010;
	bus(1'b1, 1'b0, 16'h0338, 16'h0f00);
	bus(1'b1, 1'b0, 16'h033a, 16'h0001);
	meas(2'b01, 4100, 4000, 2000, 2000);
	// breath on channel 2 with all timing codes zero, 615 ms a cycle
	i_channel_on_bit = 3'b100;
	bus(1'b1, 1'b0, 16'h0340, 16'h0004);
	meas(2'b10, 8, 6150, 1800, 3100);
	// soft start climbs from zero at the slowest interval
	i_channel_on_bit = 3'b000;
	bus(1'b1, 1'b0, 16'h0334, 16'h3007);
	bus(1'b0, 1'b0, 16'h0000, 16'h0000);
	repeat (7) @(negedge i_sys_clk);
	i_channel_on_bit = 3'b001;
	repeat (5) @(negedge i_sys_clk);
	cmp(32'(o_coarse_current_step[2:0]), 0, 0);
	repeat (1500) @(negedge i_sys_clk);
	cmp(32'(o_coarse_current_step[2:0]), 3, 3);
	bus(1'b1, 1'b0, 16'h0334, 16'h5000);
	bus(1'b1, 1'b0, 16'h033c, 16'h6000);
	bus(1'b1, 1'b0, 16'h0344, 16'h2000);
	bus(1'b0, 1'b0, 16'h0000, 16'h0000);
	repeat (6) @(negedge i_sys_clk);
	cmp(32'(o_coarse_current_step[2:0]), 5, 5);
	cmp(32'(o_coarse_current_step[5:3]), 5, 5);
	cmp(32'(o_coarse_current_step[8:6]), 2, 2);
	// a second reset clears the registers again
	i_rst = 1'b1;
	repeat (2) @(negedge i_sys_clk);
	i_rst = 1'b0;
	rd(16'h0334, 16'h0000);
	bus(1'b0, 1'b0, 16'h0000, 16'h0000);
	repeat (2) @(negedge i_sys_clk);
	results();
end
endmodule

/* design/lsb_ctrl.v */
// led sink dimming, breath and soft-start controller for three channels
`timescale 1ns/1ps
//
// Summary of operation
// - mode 00 pwm, 01 breath, 1x steady
// - duty code N gives (N+1)/32 on
// - backlight period is code plus one ticks
// - indicator period is code plus one milliseconds
// - coarse current 4 mA steps, saturates 24 mA
// - soft-start step interval 0.5 to 2 us
// - soft-start bit ramps current, else bypass
// - breath ramp time from sixteen-entry table
// - breath on hold uses ramp table
// - breath off hold from 0.246 s table
// - four 16-bit registers on channels 0 and 1, three on channel 2, reset zero
// - channel drives only while enable bit set
`include "lsb_map.vh"

module lsb_ctrl #(
	parameter MS_TICK_CYC = `LSB_MS_TICK_CYC
) (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [15:0] i_reg_addr,
	input wire [15:0] i_reg_wdata,
	output reg [15:0] o_reg_rdata,
	input wire [2:0] i_channel_on_bit,
	input wire [2:0] i_indicator_sel,
	output reg [2:0] o_sink_on,
	output reg [8:0] o_coarse_current_step
);

	// ****************************************
	// functions
	// ****************************************

	// register index of an offset, 4'hf when unmapped
	function [3:0] reg_index;
		input [15:0] addr;
		reg [15:0] rel;
		begin
			rel = addr - `LSB_OFS_SINK0_DUTY_MODE;
			if (addr < `LSB_OFS_SINK0_DUTY_MODE || addr[0] || rel[15:1] >= `LSB_REG_COUNT) begin
				reg_index = 4'hf;
			end else begin
				reg_index = rel[4:1];
			end
		end
	endfunction

	// implemented bits of a register index
	function [15:0] reg_mask;
		input [3:0] idx;
		begin
			case (idx[1:0])
				2'd0: reg_mask = `LSB_MASK_DUTY_MODE;
				2'd1: reg_mask = `LSB_MASK_DIM_FREQ;
				2'd2: reg_mask = `LSB_MASK_CURRENT_SOFTSTART;
				default: reg_mask = `LSB_MASK_BREATH_TIMING;
			endcase
		end
	endfunction

	// ramp and on-hold duration in ms
	function [12:0] ramp_ms;
		input [3:0] code;
		begin
			case (code)
				4'd0: ramp_ms = 13'd123;
				4'd1: ramp_ms = 13'd338;
				4'd2: ramp_ms = 13'd523;
				4'd3: ramp_ms = 13'd707;
				4'd4: ramp_ms = 13'd926;
				4'd5: ramp_ms = 13'd1107;
				4'd6: ramp_ms = 13'd1291;
				4'd7: ramp_ms = 13'd1507;
				4'd8: ramp_ms = 13'd1691;
				4'd9: ramp_ms = 13'd1876;
				4'd10: ramp_ms = 13'd2091;
				4'd11: ramp_ms = 13'd2276;
				4'd12: ramp_ms = 13'd2460;
				4'd13: ramp_ms = 13'd2676;
				4'd14: ramp_ms = 13'd2860;
				default: ramp_ms = 13'd3075;
			endcase
		end
	endfunction

	// off-hold duration in ms
	function [12:0] off_ms;
		input [3:0] code;
		begin
			case (code)
				4'd0: off_ms = 13'd246;
				4'd1: off_ms = 13'd677;
				4'd2: off_ms = 13'd1046;
				4'd3: off_ms = 13'd1417;
				4'd4: off_ms = 13'd1845;
				4'd5: off_ms = 13'd2214;
				4'd6: off_ms = 13'd2583;
				4'd7: off_ms = 13'd3014;
				4'd8: off_ms = 13'd3383;
				4'd9: off_ms = 13'd3752;
				4'd10: off_ms = 13'd4183;
				4'd11: off_ms = 13'd4552;
				4'd12: off_ms = 13'd4921;
				4'd13: off_ms = 13'd5351;
				4'd14: off_ms = 13'd5720;
				default: off_ms = 13'd6151;
			endcase
		end
	endfunction

	// soft-start step interval in clock cycles
	function [7:0] ss_cycles;
		input [1:0] code;
		reg [31:0] cyc;
		begin
			case (code)
				2'd0: cyc = `LSB_SS_CYC_0;
				2'd1: cyc = `LSB_SS_CYC_1;
				2'd2: cyc = `LSB_SS_CYC_2;
				default: cyc = `LSB_SS_CYC_3;
			endcase
			ss_cycles = cyc[7:0];
		end
	endfunction

	// ****************************************
	// register file
	// ****************************************

	localparam [1:0] ST_RISE = 2'd0;
	localparam [1:0] ST_HOLD_ON = 2'd1;
	localparam [1:0] ST_FALL = 2'd2;
	localparam [1:0] ST_HOLD_OFF = 2'd3;

	reg [15:0] rf [0:`LSB_REG_COUNT-1];
	wire [3:0] acc_idx = reg_index(i_reg_addr);
	integer k;

	// writes keep only implemented bits, reads of holes return zero
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			for (k = 0; k < `LSB_REG_COUNT; k = k + 1) begin
				rf[k] <= `LSB_REG_RESET;
			end
			o_reg_rdata <= 16'h0000;
		end else begin
			if (i_reg_wr && acc_idx != 4'hf) begin
				rf[acc_idx] <= i_reg_wdata & reg_mask(acc_idx);
			end
			if (i_reg_rd) begin
				o_reg_rdata <= (acc_idx != 4'hf) ? rf[acc_idx] : 16'h0000;
			end
		end
	end

	// ****************************************
	// pin synchronisers and shared time bases
	// ****************************************

	reg [2:0] en_meta;
	reg [2:0] en_sync;
	reg [2:0] ind_meta;
	reg [2:0] ind_sync;
	reg [10:0] bl_cnt;
	reg [16:0] ms_cnt;
	reg [4:0] fast_ph;
	wire bl_tick = (bl_cnt == `LSB_BL_TICK_CYC - 1);
	wire ms_tick = (ms_cnt == MS_TICK_CYC - 1);

	// two-stage sync of enables and indicator selects, free-running tick counters
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			en_meta <= 3'h0;
			en_sync <= 3'h0;
			ind_meta <= 3'h0;
			ind_sync <= 3'h0;
			bl_cnt <= 11'h000;
			ms_cnt <= 17'h0_0000;
			fast_ph <= 5'h00;
		end else begin
			en_meta <= i_channel_on_bit;
			en_sync <= en_meta;
			ind_meta <= i_indicator_sel;
			ind_sync <= ind_meta;
			bl_cnt <= bl_tick ? 11'h000 : bl_cnt + 11'h001;
			ms_cnt <= ms_tick ? 17'h0_0000 : ms_cnt + 17'h0_0001;
			fast_ph <= fast_ph + 5'h01;
		end
	end

	// ****************************************
	// per-channel engines
	// ****************************************

	// per-channel results gathered for the output registers
	wire [2:0] next_sink_on;
	wire [8:0] next_current_step;

	genvar c;
	generate
		for (c = 0; c < 3; c = c + 1) begin : g_ch
			// register fields of this channel
			wire [15:0] r_dm = rf[4*c];
			wire [15:0] r_fq = rf[4*c+1];
			wire [15:0] r_cs = rf[4*c+2];
			wire [15:0] r_bt;
			if (c < 2) begin : g_bt
				assign r_bt = rf[4*c+3];
			end else begin : g_nobt
				assign r_bt = 16'h0000;
			end
			wire [1:0] mode = r_dm[`LSB_MODE_HI:`LSB_MODE_LO];
			wire [4:0] duty = r_dm[`LSB_DUTY_HI:`LSB_DUTY_LO];
			wire [2:0] step = r_cs[`LSB_STEP_HI:`LSB_STEP_LO];
			wire ss_on = r_cs[`LSB_SSEN_BIT];
			wire [7:0] ss_len = ss_cycles(r_cs[`LSB_SSTC_HI:`LSB_SSTC_LO]);
			// codes above the top step are held at the top step
			wire [2:0] sat_step = (step > `LSB_STEP_MAX) ? `LSB_STEP_MAX : step;
			wire en = en_sync[c];
			wire is_pwm = (mode == `LSB_MODE_PWM);
			wire is_breath = (mode == `LSB_MODE_BREATH);
			wire ptick = ind_sync[c] ? ms_tick : bl_tick;
			// per-channel counters and state
			reg [15:0] per_cnt;
			reg [1:0] bst;
			reg [12:0] el_ms;
			reg [2:0] ss_lvl;
			reg [7:0] ss_cnt;
			wire [22:0] on_len = {1'b0, duty} * {1'b0, r_fq} + {1'b0, r_fq} + {6'h00, duty}
				+ 23'h00_0001;
			wire pwm_on = ({2'b00, per_cnt, 5'h00} < on_len);
			// breath phase tables and ramp brightness
			wire [12:0] ramp_t = ramp_ms(r_bt[`LSB_RAMP_HI:`LSB_RAMP_LO]);
			wire [12:0] ton_t = ramp_ms(r_bt[`LSB_TON_HI:`LSB_TON_LO]);
			wire [12:0] toff_t = off_ms(r_bt[`LSB_TOFF_HI:`LSB_TOFF_LO]);
			reg [12:0] st_len;
			reg br_on;
			wire [17:0] ph_scaled = fast_ph * ramp_t;
			wire [17:0] rise_lvl = {el_ms, 5'h00};
			wire [12:0] rem_ms = ramp_t - el_ms;
			wire [17:0] fall_lvl = {rem_ms, 5'h00};
			wire mode_on = is_pwm ? pwm_on : (is_breath ? br_on : 1'b1);

			// breath phase length and ramp brightness against a fast phase
			always @* begin
				case (bst)
					ST_RISE: begin
						st_len = ramp_t;
						br_on = ph_scaled < rise_lvl;
					end
					ST_HOLD_ON: begin
						st_len = ton_t;
						br_on = 1'b1;
					end
					ST_FALL: begin
						st_len = ramp_t;
						br_on = ph_scaled < fall_lvl;
					end
					default: begin
						st_len = toff_t;
						br_on = 1'b0;
					end
				endcase
			end

			// dimming period counter and breath sequencer
			always @(posedge i_sys_clk or posedge i_rst) begin
				if (i_rst) begin
					per_cnt <= 16'h0000;
					bst <= ST_RISE;
					el_ms <= 13'h0000;
				end else begin
					if (!en || !is_pwm) begin
						per_cnt <= 16'h0000;
					end else if (ptick) begin
						per_cnt <= (per_cnt >= r_fq) ? 16'h0000 : per_cnt + 16'h0001;
					end
					if (!en || !is_breath) begin
						bst <= ST_RISE;
						el_ms <= 13'h0000;
					end else if (ms_tick) begin
						if (el_ms + 13'h0001 >= st_len) begin
							bst <= bst + 2'd1;
							el_ms <= 13'h0000;
						end else begin
							el_ms <= el_ms + 13'h0001;
						end
					end
				end
			end

			// soft-start climbs one current step per interval after enable
			always @(posedge i_sys_clk or posedge i_rst) begin
				if (i_rst) begin
					ss_lvl <= 3'h0;
					ss_cnt <= 8'h00;
				end else if (!en) begin
					ss_lvl <= 3'h0;
					ss_cnt <= 8'h00;
				end else if (ss_lvl > sat_step) begin
					ss_lvl <= sat_step;
					ss_cnt <= 8'h00;
				end else if (ss_lvl < sat_step) begin
					if (ss_cnt + 8'h01 >= ss_len) begin
						ss_lvl <= ss_lvl + 3'h1;
						ss_cnt <= 8'h00;
					end else begin
						ss_cnt <= ss_cnt + 8'h01;
					end
				end
			end

			// combined drive and current step handed to the output registers
			assign next_sink_on[c] = en && mode_on;
			assign next_current_step[3*c+2:3*c] = ss_on ? ss_lvl : sat_step;
		end
	endgenerate

	// ****************************************
	// output registers
	// ****************************************

	// one process drives every sink and step output bit
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sink_on <= 3'h0;
			o_coarse_current_step <= 9'h000;
		end else begin
			o_sink_on <= next_sink_on;
			o_coarse_current_step <= next_current_step;
		end
	end

endmodule

/* design/lsb_map.vh */
// register map, field positions and timing constants of the led sink controller
`ifndef LSB_MAP_VH
`define LSB_MAP_VH
// register offsets
`define LSB_OFS_SINK0_DUTY_MODE 16'h0330
`define LSB_OFS_SINK0_DIM_FREQ 16'h0332
`define LSB_OFS_SINK0_CURRENT_SOFTSTART 16'h0334
`define LSB_OFS_SINK0_BREATH_TIMING 16'h0336
`define LSB_OFS_SINK1_DUTY_MODE 16'h0338
`define LSB_OFS_SINK1_DIM_FREQ 16'h033a
`define LSB_OFS_SINK1_CURRENT_SOFTSTART 16'h033c
`define LSB_OFS_SINK1_BREATH_TIMING 16'h033e
`define LSB_OFS_SINK2_DUTY_MODE 16'h0340
`define LSB_OFS_SINK2_DIM_FREQ 16'h0342
`define LSB_OFS_SINK2_CURRENT_SOFTSTART 16'h0344
`define LSB_REG_COUNT 11
`define LSB_REG_RESET 16'h0000
// implemented bits of each register kind
`define LSB_MASK_DUTY_MODE 16'h1f0c
`define LSB_MASK_DIM_FREQ 16'hffff
`define LSB_MASK_CURRENT_SOFTSTART 16'h7007
`define LSB_MASK_BREATH_TIMING 16'hff0f
// field positions
`define LSB_DUTY_HI 12
`define LSB_DUTY_LO 8
`define LSB_MODE_HI 3
`define LSB_MODE_LO 2
`define LSB_STEP_HI 14
`define LSB_STEP_LO 12
`define LSB_SSTC_HI 2
`define LSB_SSTC_LO 1
`define LSB_SSEN_BIT 0
`define LSB_RAMP_HI 15
`define LSB_RAMP_LO 12
`define LSB_TON_HI 11
`define LSB_TON_LO 8
`define LSB_TOFF_HI 3
`define LSB_TOFF_LO 0
// drive mode codes
`define LSB_MODE_PWM 2'b00
`define LSB_MODE_BREATH 2'b01
// highest current step code, larger codes draw the same current
`define LSB_STEP_MAX 3'd5
// clock and timing
`define LSB_CLK_KHZ 125000
`define LSB_BL_TICK_NS 16000
`define LSB_BL_TICK_CYC ((`LSB_BL_TICK_NS * `LSB_CLK_KHZ) / 1000000)
`define LSB_MS_TICK_US 1000
`define LSB_MS_TICK_CYC ((`LSB_MS_TICK_US * `LSB_CLK_KHZ) / 1000)
`define LSB_SS_NS_0 500
`define LSB_SS_NS_1 1000
`define LSB_SS_NS_2 1500
`define LSB_SS_NS_3 2000
`define LSB_SS_CYC_0 ((`LSB_SS_NS_0 * `LSB_CLK_KHZ + 999999) / 1000000)
`define LSB_SS_CYC_1 ((`LSB_SS_NS_1 * `LSB_CLK_KHZ + 999999) / 1000000)
`define LSB_SS_CYC_2 ((`LSB_SS_NS_2 * `LSB_CLK_KHZ + 999999) / 1000000)
`define LSB_SS_CYC_3 ((`LSB_SS_NS_3 * `LSB_CLK_KHZ + 999999) / 1000000)
`endif
